// ### hw/t1dl_regs.svh
`ifndef T1DL_REGS_SVH
`define T1DL_REGS_SVH
// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define T1DL_I_RX_CTRL1 9'h010
`define T1DL_I_RX_T1CTRL2 9'h014
`define T1DL_I_RX_CODE_CTRL 9'h015
`define T1DL_I_RX_CODE_VAL 9'h063
`define T1DL_I_RX_MSG1 9'h064
`define T1DL_I_RX_MSG2 9'h065
`define T1DL_I_RX_MSG3 9'h066
`define T1DL_I_RX_LSTAT7 9'h096
`define T1DL_I_RX_IMASK7 9'h0a6
`define T1DL_I_TX_LINK_CTRL2 9'h113
`define T1DL_I_TX_OH_BYTE 9'h162
`define T1DL_I_TX_CODE_VAL 9'h163
`define T1DL_I_TX_CTRL1 9'h181
`define T1DL_I_TX_CTRL2 9'h182
`define T1DL_I_TX_LSTAT2 9'h191
`define T1DL_I_TX_IMASK2 9'h1a1
// ****************************************************************
// field positions
// ****************************************************************
`define T1DL_B_D4_SELECT 5
`define T1DL_B_SYNC_ENABLE 4
`define T1DL_B_CODE_DET 0
`define T1DL_B_CODE_CLR 1
`define T1DL_B_MSG_UPDATE 3
`define T1DL_B_SEND_CODE 6
`define T1DL_B_PASSTHRU 6
`define T1DL_B_FDL_SOURCE 7
`define T1DL_B_FDL_EMPTY 4
// ****************************************************************
// reset values and counts
// ****************************************************************
`define T1DL_RST_BYTE 8'h00
`define T1DL_MF_FS_BITS 6'h24
`define T1DL_ALIGN_BITS 12
`define T1DL_ALIGN_PATTERN 12'h1c7
`define T1DL_BYTE_LAST_ESF 3'h7
`define T1DL_BYTE_LAST_D4 3'h5
`define T1DL_CODE_FLAG 8'hff
`define T1DL_CODE_LEN 16
`define T1DL_FILT_STEP 3'h2
`define T1DL_DIS_STEP 7'h10
`endif

// ### hw/t1dl_pkg.sv
package t1dl_pkg;
    // ****************************************************************
    // line side carriers
    // ****************************************************************
    typedef struct packed {
        logic fs_valid;
        logic fs_bit;
        logic fdl_valid;
        logic fdl_bit;
    } t1dl_rx_line_s;
    typedef struct packed {
        logic slot;
        logic fbit;
    } t1dl_tx_slot_s;
    typedef struct packed {
        logic insert;
        logic data;
    } t1dl_tx_out_s;
    typedef enum logic [1:0] {
        T1DL_SRC_NONE,
        T1DL_SRC_CODE,
        T1DL_SRC_BYTE
    } t1dl_src_e;
    typedef logic [7:0] t1dl_byte_t;
endpackage : t1dl_pkg

// ### hw/t1dl_overhead.sv
`include "t1dl_regs.svh"
// Operation
// - loop-carrier multiframe is six D4 superframes, 72 frames, fields in Fs bits.
// - 36 Ft bits; other 36 carry message fields and 12 alignment bits.
// - loading the three message registers sets update flag, status seven bit 3.
// - no update flag while the 12-bit alignment pattern is missing.
// - transmit code generator works only in T1 mode.
// - send-code bit starts code insertion at once, repeats while set, adds flag.
// - in ESF only, received data-link bits are watched for a valid code.
// - code held for filter time sets detected flag, code shown in register.
// - cleared detected flag stays clear until new code or repeat after clear.
// - code absent for disintegration time sets code-cleared flag, bit 1.
// - detected and cleared flags drive low interrupt when unmasked.
// - source-select bit shifts overhead byte as FDL in ESF, Fs in D4.
// - each overhead byte goes out least significant bit first.
// - after eight bits in ESF, six in D4, empty flag sets; unmasked it drives interrupt.
// - without a new byte within 2 ms the old byte repeats.
// - no zero stuffing on overhead byte data.
module t1dl_overhead
    import t1dl_pkg::*;
(
    input wire logic clk_i, // 100 MHz
    input wire logic rst_i, // sync reset, high
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write
    input wire logic [10:0] adr_i, // byte address
    input wire logic [3:0] sel_i, // byte enables
    input wire logic [31:0] dat_i, // write data
    output logic [31:0] dat_o, // read data
    output logic ack_o, // wishbone ack
    input wire logic t1_mode_i, // framer in T1 line mode
    input wire t1dl_rx_line_s rx_line_i, // received overhead bits
    input wire t1dl_tx_slot_s tx_slot_i, // transmit overhead slot
    output t1dl_tx_out_s tx_out_o, // overhead bit to insert
    output logic interrupt_out_n // interrupt, low active
);
    // ****************************************************************
    // registers
    // ****************************************************************
    t1dl_byte_t rx_control_one;
    t1dl_byte_t rx_t1_control_two;
    t1dl_byte_t rx_code_control;
    t1dl_byte_t rx_code_value;
    t1dl_byte_t rx_message_regs [3];
    t1dl_byte_t rx_latched_status_seven;
    t1dl_byte_t rx_interrupt_mask_seven;
    t1dl_byte_t tx_link_control_two;
    t1dl_byte_t tx_overhead_byte;
    t1dl_byte_t tx_code_value;
    t1dl_byte_t tx_control_one;
    t1dl_byte_t tx_control_two;
    t1dl_byte_t tx_latched_status_two;
    t1dl_byte_t tx_interrupt_mask_two;
    logic [8:0] idx;
    logic wr;
    logic [7:0] wd;
    logic [7:0] next_rd;
    logic d4_mode;
    logic msg_event;
    logic det_event;
    logic clr_event;
    logic empty_event;
    assign idx = adr_i[10:2];
    assign wd = dat_i[7:0];
    assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    assign d4_mode = rx_control_one[`T1DL_B_D4_SELECT];
    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    always_comb
    begin
        next_rd = `T1DL_RST_BYTE;
        case (idx)
            `T1DL_I_RX_CTRL1: next_rd = rx_control_one;
            `T1DL_I_RX_T1CTRL2: next_rd = rx_t1_control_two;
            `T1DL_I_RX_CODE_CTRL: next_rd = rx_code_control;
            `T1DL_I_RX_CODE_VAL: next_rd = rx_code_value;
            `T1DL_I_RX_MSG1: next_rd = rx_message_regs[0];
            `T1DL_I_RX_MSG2: next_rd = rx_message_regs[1];
            `T1DL_I_RX_MSG3: next_rd = rx_message_regs[2];
            `T1DL_I_RX_LSTAT7: next_rd = rx_latched_status_seven;
            `T1DL_I_RX_IMASK7: next_rd = rx_interrupt_mask_seven;
            `T1DL_I_TX_LINK_CTRL2: next_rd = tx_link_control_two;
            `T1DL_I_TX_OH_BYTE: next_rd = tx_overhead_byte;
            `T1DL_I_TX_CODE_VAL: next_rd = tx_code_value;
            `T1DL_I_TX_CTRL1: next_rd = tx_control_one;
            `T1DL_I_TX_CTRL2: next_rd = tx_control_two;
            `T1DL_I_TX_LSTAT2: next_rd = tx_latched_status_two;
            `T1DL_I_TX_IMASK2: next_rd = tx_interrupt_mask_two;
            default: next_rd = `T1DL_RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= {24'h00_0000, next_rd};
        end
    end

    // plain read/write control registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_control_one <= `T1DL_RST_BYTE;
            rx_t1_control_two <= `T1DL_RST_BYTE;
            rx_code_control <= `T1DL_RST_BYTE;
            rx_interrupt_mask_seven <= `T1DL_RST_BYTE;
            tx_link_control_two <= `T1DL_RST_BYTE;
            tx_overhead_byte <= `T1DL_RST_BYTE;
            tx_code_value <= `T1DL_RST_BYTE;
            tx_control_one <= `T1DL_RST_BYTE;
            tx_control_two <= `T1DL_RST_BYTE;
            tx_interrupt_mask_two <= `T1DL_RST_BYTE;
        end
        else if (wr)
        begin
            case (idx)
                `T1DL_I_RX_CTRL1: rx_control_one <= wd;
                `T1DL_I_RX_T1CTRL2: rx_t1_control_two <= wd;
                `T1DL_I_RX_CODE_CTRL: rx_code_control <= wd;
                `T1DL_I_RX_IMASK7: rx_interrupt_mask_seven <= wd;
                `T1DL_I_TX_LINK_CTRL2: tx_link_control_two <= wd;
                `T1DL_I_TX_OH_BYTE: tx_overhead_byte <= wd;
                `T1DL_I_TX_CODE_VAL: tx_code_value <= wd;
                `T1DL_I_TX_CTRL1: tx_control_one <= wd;
                `T1DL_I_TX_CTRL2: tx_control_two <= wd;
                `T1DL_I_TX_IMASK2: tx_interrupt_mask_two <= wd;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // latched status, write one to clear, set wins
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_latched_status_seven <= `T1DL_RST_BYTE;
            tx_latched_status_two <= `T1DL_RST_BYTE;
        end
        else
        begin
            rx_latched_status_seven <= (rx_latched_status_seven
                & ~((wr && idx == `T1DL_I_RX_LSTAT7) ? wd : 8'h00))
                | (8'(msg_event) << `T1DL_B_MSG_UPDATE)
                | (8'(det_event) << `T1DL_B_CODE_DET)
                | (8'(clr_event) << `T1DL_B_CODE_CLR);
            tx_latched_status_two <= (tx_latched_status_two
                & ~((wr && idx == `T1DL_I_TX_LSTAT2) ? wd : 8'h00))
                | (8'(empty_event) << `T1DL_B_FDL_EMPTY);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            interrupt_out_n <= 1'b1;
        else
            interrupt_out_n <= !(
                (rx_latched_status_seven[`T1DL_B_CODE_DET]
                    && rx_interrupt_mask_seven[`T1DL_B_CODE_DET])
                || (rx_latched_status_seven[`T1DL_B_CODE_CLR]
                    && rx_interrupt_mask_seven[`T1DL_B_CODE_CLR])
                || (tx_latched_status_two[`T1DL_B_FDL_EMPTY]
                    && tx_interrupt_mask_two[`T1DL_B_FDL_EMPTY]));
    end

    // ****************************************************************
    // receive loop-carrier message extraction
    // ****************************************************************
    logic [35:0] fs_shift;
    logic [5:0] fs_count;
    logic aligned;
    assign aligned = fs_shift[`T1DL_ALIGN_BITS-1:0] == `T1DL_ALIGN_PATTERN;
    // one Fs bit per two frames: 36 per 72-frame multiframe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fs_shift <= 36'h0_0000_0000;
            fs_count <= 6'h00;
            msg_event <= 1'b0;
            for (int i = 0; i < 3; i++)
                rx_message_regs[i] <= `T1DL_RST_BYTE;
        end
        else
        begin
            msg_event <= 1'b0;
            if (rx_line_i.fs_valid && t1_mode_i && d4_mode
                && rx_t1_control_two[`T1DL_B_SYNC_ENABLE])
            begin
                fs_shift <= {rx_line_i.fs_bit, fs_shift[35:1]};
                if (fs_count != `T1DL_MF_FS_BITS)
                    fs_count <= fs_count + 6'h01;
            end
            else if (fs_count == `T1DL_MF_FS_BITS)
            begin
                fs_count <= 6'h00;
                if (aligned)
                begin
                    msg_event <= 1'b1;
                    for (int i = 0; i < 3; i++)
                        rx_message_regs[i] <= fs_shift[12+8*i +: 8];
                end
            end
        end
    end

    // ****************************************************************
    // receive code detector
    // ****************************************************************
    logic [15:0] code_shift;
    logic [5:0] cand_code;
    logic [2:0] match_cnt;
    logic [6:0] gap_cnt;
    logic present;
    logic frame_ok;
    logic [5:0] seen_code;
    logic [2:0] need;
    logic [6:0] gap_limit;
    // flag first, then 0, code LSB first, closing 0
    assign frame_ok = code_shift[7:0] == `T1DL_CODE_FLAG
        && !code_shift[8] && !code_shift[15];
    assign seen_code = code_shift[14:9];
    assign need = 3'h1 + `T1DL_FILT_STEP * {1'b0, rx_code_control[1:0]};
    assign gap_limit = `T1DL_DIS_STEP * (7'h1 + {5'h00, rx_code_control[5:4]});
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            code_shift <= 16'h0000;
            cand_code <= 6'h00;
            match_cnt <= 3'h0;
            gap_cnt <= 7'h00;
            present <= 1'b0;
            rx_code_value <= `T1DL_RST_BYTE;
            det_event <= 1'b0;
            clr_event <= 1'b0;
        end
        else
        begin
            det_event <= 1'b0;
            clr_event <= 1'b0;
            if (rx_line_i.fdl_valid && t1_mode_i && !d4_mode)
            begin
                code_shift <= {rx_line_i.fdl_bit, code_shift[15:1]};
                if (frame_ok)
                begin
                    gap_cnt <= 7'h00;
                    code_shift <= {rx_line_i.fdl_bit, 15'h7fff};
                    if (seen_code != cand_code || match_cnt == 3'h0)
                    begin
                        cand_code <= seen_code;
                        match_cnt <= 3'h1;
                    end
                    else if (match_cnt != need)
                        match_cnt <= match_cnt + 3'h1;
                    if ((match_cnt + 3'h1 >= need || (seen_code == cand_code
                        && match_cnt == need)) && seen_code == cand_code
                        && (!present || rx_code_value[5:0] != seen_code))
                    begin
                        present <= 1'b1;
                        det_event <= 1'b1;
                        rx_code_value <= {2'b00, seen_code};
                    end
                end
                else if (gap_cnt != gap_limit)
                    gap_cnt <= gap_cnt + 7'h01;
                else if (present)
                begin
                    present <= 1'b0;
                    match_cnt <= 3'h0;
                    clr_event <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // transmit code generator and overhead byte shifter
    // ****************************************************************
    logic [3:0] code_pos;
    logic [15:0] code_word;
    logic [7:0] byte_shift;
    logic [2:0] byte_pos;
    logic [2:0] byte_last;
    t1dl_src_e src;
    assign code_word = {1'b0, tx_code_value[5:0], 1'b0, `T1DL_CODE_FLAG};
    assign byte_last = d4_mode ? `T1DL_BYTE_LAST_D4 : `T1DL_BYTE_LAST_ESF;
    always_comb
    begin
        src = T1DL_SRC_NONE;
        if (t1_mode_i && tx_link_control_two[`T1DL_B_SEND_CODE])
            src = T1DL_SRC_CODE;
        else if (tx_control_two[`T1DL_B_FDL_SOURCE])
            src = T1DL_SRC_BYTE;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            code_pos <= 4'h0;
        else if (src != T1DL_SRC_CODE)
            code_pos <= 4'h0;
        else if (tx_slot_i.slot)
            code_pos <= code_pos + 4'h1;
    end

    // raw bits, no zero stuffing; old byte reloaded if not rewritten
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            byte_shift <= `T1DL_RST_BYTE;
            byte_pos <= 3'h0;
            empty_event <= 1'b0;
        end
        else
        begin
            empty_event <= 1'b0;
            if (src != T1DL_SRC_BYTE)
            begin
                byte_pos <= 3'h0;
                byte_shift <= tx_overhead_byte;
            end
            else if (tx_slot_i.slot)
            begin
                if (byte_pos == byte_last)
                begin
                    byte_pos <= 3'h0;
                    byte_shift <= tx_overhead_byte;
                    empty_event <= 1'b1;
                end
                else
                begin
                    byte_pos <= byte_pos + 3'h1;
                    byte_shift <= {1'b0, byte_shift[7:1]};
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tx_out_o <= '0;
        else
        begin
            tx_out_o.insert <= !tx_control_one[`T1DL_B_PASSTHRU]
                && src != T1DL_SRC_NONE;
            case (src)
                T1DL_SRC_CODE: tx_out_o.data <= code_word[code_pos];
                T1DL_SRC_BYTE: tx_out_o.data <= byte_shift[0];
                T1DL_SRC_NONE: tx_out_o.data <= tx_slot_i.fbit;
                default: tx_out_o.data <= tx_slot_i.fbit;
            endcase
        end
    end
endmodule : t1dl_overhead

// ### tb/t1dl_overhead_sva.sv
`include "t1dl_regs.svh"
module t1dl_overhead_sva
    import t1dl_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic cyc_i, // cycle
    input wire logic stb_i, // strobe
    input wire logic we_i, // write
    input wire logic [10:0] adr_i, // address
    input wire logic [3:0] sel_i, // lanes
    input wire logic [31:0] dat_i, // write data
    input wire logic [31:0] dat_o, // read data
    input wire logic ack_o, // ack
    input wire logic t1_mode_i, // t1 mode
    input wire t1dl_rx_line_s rx_line_i, // rx bits
    input wire t1dl_tx_slot_s tx_slot_i, // tx slot
    input wire t1dl_tx_out_s tx_out_o, // tx out
    input wire logic interrupt_out_n // irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********
    // shadow of control bits
    // ********
    logic pass_thru;
    logic send_code;
    logic byte_src;
    logic [1:0] mask7;
    logic mask2;
    logic irq_en;
    assign irq_en = (|mask7) || mask2;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pass_thru <= 1'h0;
            send_code <= 1'h0;
            byte_src <= 1'h0;
            mask7 <= 2'h0;
            mask2 <= 1'h0;
        end
        else if (cyc_i && stb_i && we_i && ack_o && sel_i[0])
        begin
            case (adr_i[10:2])
                `T1DL_I_TX_CTRL1: pass_thru <= dat_i[6];
                `T1DL_I_TX_LINK_CTRL2: send_code <= dat_i[6];
                `T1DL_I_TX_CTRL2: byte_src <= dat_i[7];
                `T1DL_I_RX_IMASK7: mask7 <= dat_i[1:0];
                `T1DL_I_TX_IMASK2: mask2 <= dat_i[4];
                default: ;
            endcase
        end
    end
    // ********
    // properties
    // ********
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than a cycle");
    property p_ack_resp; cyc_i && stb_i && !ack_o && !$past(ack_o) |=> ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
    property p_rd_high; ack_o |-> dat_o[31:8] == 24'h00_0000; endproperty
    a_rd_high: assert property (p_rd_high) else $error("read data upper bits set");
    property p_rst; $past(rst_i) |-> interrupt_out_n && !ack_o && !tx_out_o.insert; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_pass; pass_thru && $past(pass_thru) |-> !tx_out_o.insert; endproperty
    a_pass: assert property (p_pass) else $error("insert with pass-through");
    property p_idle; !send_code && !byte_src && $past(!send_code && !byte_src)
        |-> !tx_out_o.insert; endproperty
    a_idle: assert property (p_idle) else $error("insert with no source");
    property p_mode; !t1_mode_i && !byte_src && $past(!t1_mode_i && !byte_src)
        |-> !tx_out_o.insert; endproperty
    a_mode: assert property (p_mode) else $error("code sent outside t1");
    property p_code_on; t1_mode_i && send_code && !pass_thru
        && $past(t1_mode_i && send_code && !pass_thru) |-> tx_out_o.insert; endproperty
    a_code_on: assert property (p_code_on) else $error("code not inserted");
    property p_irq; !interrupt_out_n |-> $past(irq_en); endproperty
    a_irq: assert property (p_irq) else $error("interrupt while masked");
endmodule : t1dl_overhead_sva

// ### tb/t1dl_line_model.sv
module t1dl_line_model
    import t1dl_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic code_on_i, // send codewords
    input wire logic fs_on_i, // send fs bits
    input wire logic [5:0] code_i, // code
    input wire logic [35:0] fs_word_i, // multiframe fs bits
    input wire t1dl_tx_out_s tx_out_i, // tx out
    output t1dl_rx_line_s rx_line_o, // rx bits
    output t1dl_tx_slot_s tx_slot_o, // tx slot
    output logic [15:0] cap_o // last tx bits
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********
    // bit timing and capture
    // ********
    logic [3:0] tick;
    logic [3:0] pc;
    logic [5:0] ps;
    logic stb;
    logic slot_d;
    logic [15:0] cw;
    assign stb = tick == 4'hf;
    assign cw = {1'h0, code_i, 1'h0, 8'hff};
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tick <= 4'h0;
            pc <= 4'h0;
            ps <= 6'h00;
            slot_d <= 1'h0;
            cap_o <= 16'h0000;
        end
        else
        begin
            tick <= tick + 4'h1;
            slot_d <= stb;
            pc <= !code_on_i ? 4'h0 : pc + {3'h0, stb};
            ps <= !fs_on_i ? 6'h00 : !stb ? ps : (ps == 6'h23) ? 6'h00 : ps + 6'h01;
            if (slot_d)
                cap_o <= {tx_out_i.data, cap_o[15:1]};
        end
    end
    // idle data lines toggle so a stale level never looks valid
    always_comb
    begin
        rx_line_o.fdl_valid = stb;
        rx_line_o.fdl_bit = (code_on_i ? cw[pc] : 1'h1) ^ !stb;
        rx_line_o.fs_valid = stb && fs_on_i;
        rx_line_o.fs_bit = fs_word_i[ps] ^ !(stb && fs_on_i);
        tx_slot_o.slot = stb;
        tx_slot_o.fbit = tick[0];
    end
endmodule : t1dl_line_model

// ### tb/tb_t1dl_overhead.sv
`include "t1dl_regs.svh"
module tb_t1dl_overhead
    import t1dl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc_i = 1'h0;
    logic stb_i = 1'h0;
    logic we_i = 1'h0;
    logic [10:0] adr_i = 11'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic t1_mode_i = 1'h1;
    logic code_on = 1'h0;
    logic fs_on = 1'h0;
    logic [5:0] code = 6'h00;
    logic [35:0] fs_word = 36'h0_0000_0000;
    logic [31:0] dat_o;
    logic ack_o;
    logic interrupt_out_n;
    t1dl_rx_line_s rx_line;
    t1dl_tx_slot_s tx_slot;
    t1dl_tx_out_s tx_out;
    logic [15:0] cap;
    t1dl_byte_t q;
    int n_mismatch = 0;
    int check_count = 0;
    logic [8:0] idx_list [7] = '{`T1DL_I_RX_CODE_CTRL, `T1DL_I_RX_CODE_VAL,
        `T1DL_I_RX_LSTAT7, `T1DL_I_TX_OH_BYTE, `T1DL_I_TX_LSTAT2, `T1DL_I_TX_CTRL2, 9'h1ff};
    always #5 clk_i = ~clk_i;
    t1dl_overhead dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .t1_mode_i, .rx_line_i(rx_line), .tx_slot_i(tx_slot),
        .tx_out_o(tx_out), .interrupt_out_n);
    t1dl_line_model line (.clk_i, .rst_i, .code_on_i(code_on), .fs_on_i(fs_on),
        .code_i(code), .fs_word_i(fs_word), .tx_out_i(tx_out), .rx_line_o(rx_line),
        .tx_slot_o(tx_slot), .cap_o(cap));
    // ********
    // tasks
    // ********
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic hang();
        n_mismatch++;
        $display("MISMATCH t=%0t wait timed out", $time);
        tally_and_finish();
    endtask : hang
    task automatic wb(input logic w, input logic [8:0] a, input t1dl_byte_t d);
        int n;
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= {a, 2'h0};
        sel_i <= 4'h1;
        dat_i <= {24'h00_0000, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'h1 && n < 20);
        if (ack_o !== 1'h1)
            hang();
        q = dat_o[7:0];
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i <= 1'h0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [8:0] a, input t1dl_byte_t d);
        wb(1'h1, a, d);
    endtask : wr
    task automatic rd(input logic [8:0] a, input t1dl_byte_t e);
        wb(1'h0, a, 8'h00);
        chk(q, e);
    endtask : rd
    task automatic wint();
        int n;
        // skip the edge that still shows a just-cleared interrupt
        @(posedge clk_i);
        for (n = 0; n < 3000 && interrupt_out_n !== 1'h0; n++)
            @(posedge clk_i);
        if (n == 3000)
            hang();
    endtask : wint
    function automatic logic rot_has(input logic [15:0] c, input logic [15:0] e);
        logic [31:0] d;
        d = {c, c};
        for (int i = 0; i < 16; i++)
            if (d[i+:16] === e)
                return 1'h1;
        return 1'h0;
    endfunction : rot_has
    // ********
    // sequence
    // ********
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        wr(9'h1ff, 8'hff);
        foreach (idx_list[i]) rd(idx_list[i], 8'h00);
        chk(interrupt_out_n, 1'h1);
        wr(`T1DL_I_RX_CODE_CTRL, 8'h11);
        rd(`T1DL_I_RX_CODE_CTRL, 8'h11);
        wr(`T1DL_I_RX_IMASK7, 8'h03);
        code <= 6'h2a;
        code_on <= 1'h1;
        // three codewords needed: two are not enough
        repeat (600) @(posedge clk_i);
        rd(`T1DL_I_RX_LSTAT7, 8'h00);
        wint();
        rd(`T1DL_I_RX_LSTAT7, 8'h01);
        rd(`T1DL_I_RX_CODE_VAL, 8'h2a);
        wr(`T1DL_I_RX_LSTAT7, 8'h01);
        repeat (600) @(posedge clk_i);
        rd(`T1DL_I_RX_LSTAT7, 8'h00);
        chk(interrupt_out_n, 1'h1);
        code_on <= 1'h0;
        wint();
        rd(`T1DL_I_RX_LSTAT7, 8'h02);
        wr(`T1DL_I_RX_LSTAT7, 8'h03);
        wr(`T1DL_I_RX_IMASK7, 8'h00);
        wr(`T1DL_I_RX_CTRL1, 8'h20);
        wr(`T1DL_I_RX_T1CTRL2, 8'h10);
        fs_word <= {8'h5c, 8'h3a, 8'h96, 12'h1c7};
        code_on <= 1'h1;
        fs_on <= 1'h1;
        repeat (700) @(posedge clk_i);
        rd(`T1DL_I_RX_LSTAT7, 8'h08);
        rd(`T1DL_I_RX_MSG1, 8'h96);
        rd(`T1DL_I_RX_MSG2, 8'h3a);
        rd(`T1DL_I_RX_MSG3, 8'h5c);
        wr(`T1DL_I_RX_LSTAT7, 8'h08);
        fs_word <= {8'h5c, 8'h3a, 8'h96, 12'h9c7};
        repeat (1300) @(posedge clk_i);
        rd(`T1DL_I_RX_LSTAT7, 8'h00);
        fs_on <= 1'h0;
        code_on <= 1'h0;
        wr(`T1DL_I_RX_CTRL1, 8'h00);
        wr(`T1DL_I_TX_IMASK2, 8'h10);
        wr(`T1DL_I_TX_OH_BYTE, 8'h3f);
        wr(`T1DL_I_TX_CTRL2, 8'h80);
        wint();
        wr(`T1DL_I_TX_LSTAT2, 8'h10);
        wint();
        chk(cap[15:8], 8'h3f);
        rd(`T1DL_I_TX_LSTAT2, 8'h10);
        wr(`T1DL_I_TX_LSTAT2, 8'h10);
        wint();
        chk(cap[15:8], 8'h3f);
        wr(`T1DL_I_RX_CTRL1, 8'h20);
        wr(`T1DL_I_TX_OH_BYTE, 8'h1c);
        wr(`T1DL_I_TX_LSTAT2, 8'h10);
        wint();
        wr(`T1DL_I_TX_LSTAT2, 8'h10);
        wint();
        chk(cap[15:10], 6'h1c);
        wr(`T1DL_I_TX_CTRL2, 8'h00);
        wr(`T1DL_I_TX_LSTAT2, 8'h10);
        wr(`T1DL_I_TX_IMASK2, 8'h00);
        wr(`T1DL_I_RX_CTRL1, 8'h00);
        wr(`T1DL_I_TX_CODE_VAL, 8'hea);
        wr(`T1DL_I_TX_LINK_CTRL2, 8'h40);
        repeat (330) @(posedge clk_i);
        chk(rot_has(cap, {1'h0, 6'h2a, 1'h0, 8'hff}), 1'h1);
        chk(tx_out.insert, 1'h1);
        wr(`T1DL_I_TX_CTRL1, 8'h40);
        repeat (3) @(posedge clk_i);
        chk(tx_out.insert, 1'h0);
        wr(`T1DL_I_TX_CTRL1, 8'h00);
        t1_mode_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        chk(tx_out.insert, 1'h0);
        tally_and_finish();
    end
endmodule : tb_t1dl_overhead
bind t1dl_overhead t1dl_overhead_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .t1_mode_i, .rx_line_i, .tx_slot_i, .tx_out_o,
    .interrupt_out_n);
